// >>> hdl/bsr_params.svh
// Constants for the bit shift register unit.
`ifndef BSR_PARAMS_SVH
`define BSR_PARAMS_SVH

// ==========================================================================
// Sizes
// ==========================================================================
`define BSR_MAX_LEN        64
`define BSR_BYTE_BITS      8
`define BSR_MEM_BYTES      4096

// ==========================================================================
// Error codes
// ==========================================================================
`define BSR_ERR_NONE       16'h0000
`define BSR_ERR_INDIRECT   16'h0006
`define BSR_ERR_RANGE      16'h0091
`define BSR_ERR_COUNT      16'h0092

`endif

// >>> hdl/bsr_pkg.sv
// Types shared by the bit shift register unit.
package bsr_pkg;

  // ========================================================================
  // Command from the sequencer and request to the bit memory
  // ========================================================================
  typedef struct packed {
    logic               data_bit;
    logic        [15:0] byte_addr;
    logic        [2:0]  bit_idx;
    logic signed [7:0]  length;
  } bsr_cmd_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bsr_mem_s;

  typedef enum logic [2:0] {
    BSR_IDLE  = 3'h0,
    BSR_READ  = 3'h1,
    BSR_SHIFT = 3'h3,
    BSR_WRITE = 3'h2,
    BSR_DONE  = 3'h6
  } bsr_state_e;

endpackage : bsr_pkg

// >>> hdl/bsr_unit.sv
// Bit shift register unit working on a byte-wide bit memory.
// Summary of operation
// RULE_01: Each execution inserts the input bit into the register starting at start bit.
// RULE_02: Length magnitude gives size; sign gives direction, positive plus, negative minus.
// RULE_03: The bit expelled by an execution replaces the overflow flag.
// RULE_04: Run-time, indirect, range or count faults drive success low with an error code; a run-time fault leaves the code at none.
// RULE_05: Top bit is start byte plus (start bit + length - 1)/8, remainder bit.
// RULE_06: Negative length loads top bit, moves bits toward start, expels start bit.
// RULE_07: Positive length loads start bit, moves bits upward, expels old top bit.
// RULE_08: Register lengths up to 64 bits are handled in both directions.
// RULE_09: Sequencer issues at most one execution per scan; each moves one bit.
// RULE_10: Zero or oversized length is a count error; register and flag stay unchanged.
`timescale 1ns/1ns
`include "bsr_params.svh"

module bsr_unit
  import bsr_pkg::*;
#(
  parameter int MAX_LEN   = `BSR_MAX_LEN,
  parameter int MEM_BYTES = `BSR_MEM_BYTES
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        start_i,
  input  wire bsr_cmd_s    cmd_i,
  input  wire logic        runtime_fault_flag_i,
  input  wire logic        indirect_fault_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             success_out_o,
  output logic [15:0]      error_code_o,
  output logic             overflow_flag_o,
  output bsr_mem_s         mem_o,
  input  wire logic        mem_ack_i,
  input  wire logic [7:0]  mem_rdata_i
);

  localparam int WIN = MAX_LEN + `BSR_BYTE_BITS;

  // ========================================================================
  // Helpers
  // ========================================================================
  function automatic logic [7:0] mag_of(input logic signed [7:0] n);
    return n[7] ? 8'(-n) : 8'(n);
  endfunction : mag_of

  // Returns the expelled bit above the new window contents.
  function automatic logic [WIN:0] shift_win(input logic [WIN-1:0] w,
                                             input logic [6:0] lo,
                                             input logic [6:0] hi,
                                             input logic minus,
                                             input logic din);
    logic [WIN-1:0] n;
    logic           out;
    n   = w;
    out = minus ? w[lo] : w[hi];
    for (int i = 0; i < WIN; i++) begin
      if (!minus && i > 0 && i > int'(lo) && i <= int'(hi)) begin
        n[i] = w[i-1];                                          // [RULE_07]
      end else if (minus && i < WIN - 1 && i >= int'(lo) && i < int'(hi)) begin
        n[i] = w[i+1];                                          // [RULE_06]
      end
    end
    if (minus) begin
      n[hi] = din;                                              // [RULE_06]
    end else begin
      n[lo] = din;                                              // [RULE_07]
    end
    return {out, n};
  endfunction : shift_win

  // ========================================================================
  // Command decode
  // ========================================================================
  bsr_state_e       state;
  bsr_cmd_s         cmd;
  logic [WIN-1:0]   win;
  logic [3:0]       idx;
  logic [3:0]       last;
  logic [6:0]       lo;
  logic [6:0]       hi;
  logic [7:0]       mag;
  logic [7:0]       top;
  logic             len_bad;
  logic             range_bad;
  logic [WIN:0]     next_win;

  assign mag       = mag_of(cmd_i.length);                      // [RULE_02]
  assign top       = 8'({5'h00, cmd_i.bit_idx} + mag - 8'h01);  // [RULE_05]
  assign len_bad   = (mag == 8'h00) || (int'(mag) > MAX_LEN);   // [RULE_10] [RULE_08]
  assign range_bad = (int'(cmd_i.byte_addr) + int'(top[7:3])) >= MEM_BYTES;
  assign lo        = {4'h0, cmd.bit_idx};
  assign next_win  = shift_win(win, lo, hi, cmd.length[7], cmd.data_bit);

  assign busy_o = (state != BSR_IDLE);
  assign done_o = (state == BSR_DONE);

  // ========================================================================
  // Sequencer
  // ========================================================================
  // The sequencer gives one start per scan; starts while busy are ignored.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= BSR_IDLE;
    end else begin
      case (state)
        BSR_IDLE: begin
          if (start_i) begin                                     // [RULE_09]
            if (runtime_fault_flag_i || indirect_fault_i || len_bad || range_bad) begin
              state <= BSR_DONE;                                 // [RULE_04]
            end else begin
              state <= BSR_READ;
            end
          end
        end
        BSR_READ:  state <= (mem_ack_i && idx == last) ? BSR_SHIFT : BSR_READ;
        BSR_SHIFT: state <= BSR_WRITE;
        BSR_WRITE: state <= (mem_ack_i && idx == last) ? BSR_DONE : BSR_WRITE;
        BSR_DONE:  state <= BSR_IDLE;
        default:   state <= BSR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd  <= '0;
      last <= 4'h0;
      hi   <= 7'h00;
    end else if (state == BSR_IDLE && start_i) begin
      cmd  <= cmd_i;
      last <= top[6:3];                                          // [RULE_05]
      hi   <= top[6:0];
    end
  end

  // Byte counter walks the span once for reading and once for writing.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      idx <= 4'h0;
    end else if (state == BSR_IDLE || state == BSR_SHIFT) begin
      idx <= 4'h0;
    end else if ((state == BSR_READ || state == BSR_WRITE) && mem_ack_i && idx != last) begin
      idx <= idx + 4'h1;
    end
  end

  // ========================================================================
  // Window and overflow
  // ========================================================================
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      win <= '0;
    end else if (state == BSR_READ && mem_ack_i) begin
      win[idx*8 +: 8] <= mem_rdata_i;
    end else if (state == BSR_SHIFT) begin
      win <= next_win[WIN-1:0];                                  // [RULE_01]
    end
  end

  // Error paths never reach the shift state, so the flag is untouched there.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      overflow_flag_o <= 1'b0;
    end else if (state == BSR_SHIFT) begin
      overflow_flag_o <= next_win[WIN];                          // [RULE_03]
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      success_out_o <= 1'b0;
      error_code_o  <= `BSR_ERR_NONE;
    end else if (state == BSR_IDLE && start_i) begin
      success_out_o <= 1'b0;                                     // [RULE_04]
      if (runtime_fault_flag_i) begin
        error_code_o <= `BSR_ERR_NONE;
      end else if (indirect_fault_i) begin
        error_code_o <= `BSR_ERR_INDIRECT;
      end else if (len_bad) begin
        error_code_o <= `BSR_ERR_COUNT;                          // [RULE_10]
      end else if (range_bad) begin
        error_code_o <= `BSR_ERR_RANGE;
      end else begin
        error_code_o <= `BSR_ERR_NONE;
      end
    end else if (state == BSR_WRITE && mem_ack_i && idx == last) begin
      success_out_o <= 1'b1;
    end
  end

  // Request held until acknowledged; the write data comes from the window flops.
  always_comb begin
    mem_o       = '0;
    mem_o.req   = (state == BSR_READ) || (state == BSR_WRITE);
    mem_o.we    = (state == BSR_WRITE);
    mem_o.addr  = cmd.byte_addr + {12'h000, idx};
    mem_o.wdata = win[idx*8 +: 8];
  end

  // ========================================================================
  // Checks
  // ========================================================================
  property p_insert_plus;
    @(posedge clk_i) disable iff (reset_i)
    (state == BSR_SHIFT && !cmd.length[7]) |=> win[lo] == cmd.data_bit;
  endproperty
  a_insert_plus: assert property (p_insert_plus) // [RULE_01]
    else $error("input bit not at start bit");

  property p_insert_minus;
    @(posedge clk_i) disable iff (reset_i)
    (state == BSR_SHIFT && cmd.length[7]) |=> win[hi] == cmd.data_bit;
  endproperty
  a_insert_minus: assert property (p_insert_minus) // [RULE_02]
    else $error("input bit not at top bit on minus shift");

  property p_overflow;
    @(posedge clk_i) disable iff (reset_i)
    state == BSR_SHIFT |=>
      overflow_flag_o == (cmd.length[7] ? $past(win[lo]) : $past(win[hi]));
  endproperty
  a_overflow: assert property (p_overflow) // [RULE_03]
    else $error("overflow flag not the expelled bit");

  property p_fault;
    @(posedge clk_i) disable iff (reset_i)
    (state == BSR_IDLE && start_i && (runtime_fault_flag_i || indirect_fault_i))
      |=> done_o && !success_out_o ##1 !busy_o;
  endproperty
  a_fault: assert property (p_fault) // [RULE_04]
    else $error("fault did not end with success low");

  property p_top_byte;
    @(posedge clk_i) disable iff (reset_i)
    (state == BSR_IDLE && start_i)
      |=> last == 4'(({5'h00, $past(cmd_i.bit_idx)} + $past(mag) - 8'h01) >> 3);
  endproperty
  a_top_byte: assert property (p_top_byte) // [RULE_05]
    else $error("top byte offset wrong");

  property p_move_down;
    @(posedge clk_i) disable iff (reset_i)
    (state == BSR_SHIFT && cmd.length[7] && hi > lo) |=> win[lo] == $past(win[lo + 7'h01]);
  endproperty
  a_move_down: assert property (p_move_down) // [RULE_06]
    else $error("minus shift did not move toward start");

  property p_move_up;
    @(posedge clk_i) disable iff (reset_i)
    (state == BSR_SHIFT && !cmd.length[7] && hi > lo) |=> win[hi] == $past(win[hi - 7'h01]);
  endproperty
  a_move_up: assert property (p_move_up) // [RULE_07]
    else $error("plus shift did not move toward top");

  property p_full_len;
    @(posedge clk_i) disable iff (reset_i)
    (state == BSR_IDLE && start_i && mag == 8'(MAX_LEN) && !range_bad
      && !runtime_fault_flag_i && !indirect_fault_i) |=> state == BSR_READ;
  endproperty
  a_full_len: assert property (p_full_len) // [RULE_08]
    else $error("maximum length refused");

  property p_bad_len;
    @(posedge clk_i) disable iff (reset_i)
    (state == BSR_IDLE && start_i && len_bad && !runtime_fault_flag_i && !indirect_fault_i)
      |=> done_o && error_code_o == `BSR_ERR_COUNT && $stable(overflow_flag_o)
          && $stable(win);
  endproperty
  a_bad_len: assert property (p_bad_len) // [RULE_10]
    else $error("bad length not rejected cleanly");

endmodule : bsr_unit

// >>> tb/bsr_mem_model.sv
// Behavioural byte-wide bit memory that answers the unit's requests.
`timescale 1ns/1ns

module bsr_mem_model
  import bsr_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     slow_i,
  input  wire bsr_mem_s mem_i,
  output logic          ack_o,
  output logic [7:0]    rdata_o
);
  logic [7:0] mem [256];
  logic       phase = 1'b0;

  // ==========================================================================
  // Handshake and storage
  // ==========================================================================
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i * 37) ^ 8'ha5;
    end
  end

  // Slow mode grants only every other cycle, so the unit must hold its request.
  assign ack_o = mem_i.req && (!slow_i || phase);

  // Outside an accepted read the lines show the inverse, never the stored byte.
  assign rdata_o = (ack_o && !mem_i.we) ? mem[mem_i.addr[7:0]] : ~mem[mem_i.addr[7:0]];

  always @(posedge clk_i) begin
    phase <= ~phase;
    if (mem_i.req && ack_o && mem_i.we) begin
      mem[mem_i.addr[7:0]] <= mem_i.wdata;
    end
  end
endmodule : bsr_mem_model

// >>> tb/tb_top.sv
// Self-checking testbench for the bit shift register unit.
`timescale 1ns/1ns
`include "bsr_params.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end

module tb_top
  import bsr_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic        rt = 1'b0;
  logic        ind = 1'b0;
  logic        slow = 1'b0;
  bsr_cmd_s    cmd = '0;
  logic        busy;
  logic        done;
  logic        ok_o;
  logic        ovf;
  logic        ack;
  logic [15:0] ecode;
  logic [7:0]  rdata;
  bsr_mem_s    mem;
  logic [7:0]  mref [256];
  logic        exp_ov = 1'b0;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;

  always #5 clk = ~clk;

  bsr_unit #(.MEM_BYTES(256)) bsr_unit_i (
    .clk_i(clk), .reset_i(rst), .start_i(start), .cmd_i(cmd),
    .runtime_fault_flag_i(rt), .indirect_fault_i(ind), .busy_o(busy),
    .done_o(done), .success_out_o(ok_o), .error_code_o(ecode),
    .overflow_flag_o(ovf), .mem_o(mem), .mem_ack_i(ack), .mem_rdata_i(rdata)
  );

  bsr_mem_model bsr_mem_model_i (
    .clk_i(clk), .slow_i(slow), .mem_i(mem), .ack_o(ack), .rdata_o(rdata)
  );

  // ==========================================================================
  // Reference memory and operation task
  // ==========================================================================
  function automatic logic getb(input int x);
    return mref[x >> 3][x & 7];
  endfunction : getb

  task automatic setb(input int x, input logic v);
    mref[x >> 3][x & 7] = v;
  endtask : setb

  task end_of_test;
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  // One execution; on accepted commands start is held one extra cycle while busy, which must be ignored.
  task automatic op(input logic d, input logic [15:0] a, input logic [2:0] b,
                    input logic signed [7:0] n, input logic f_rt, input logic f_ind,
                    input logic [15:0] ec);
    int   p;
    int   m;
    int   k;
    logic ok;
    p  = a * 8 + b;
    m  = (n < 0) ? -n : n;
    ok = !f_rt && !f_ind && ec == 16'h0000;
    if (ok && n > 0) begin
      exp_ov = getb(p + m - 1);
      for (k = m - 1; k > 0; k--) setb(p + k, getb(p + k - 1));
      setb(p, d);
    end else if (ok) begin
      exp_ov = getb(p);
      for (k = 0; k < m - 1; k++) setb(p + k, getb(p + k + 1));
      setb(p + m - 1, d);
    end
    // A start during the done cycle would be ignored, so let the unit return to idle.
    if (busy === 1'b1) begin
      @(posedge clk);
      #1;
    end
    cmd   = '{d, a, b, n};
    rt    = f_rt;
    ind   = f_ind;
    start = 1'b1;
    @(posedge clk);
    #1;
    `CHK(busy, 1'b1)
    for (k = 0; k < 300 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
      start = 1'b0;
    end
    start = 1'b0;
    if (k == 300) miscompares++;
    `CHK(ok_o, ok)
    `CHK(ecode, ec)
    `CHK(ovf, exp_ov)
    for (k = 0; k < 256; k++) `CHK(bsr_mem_model_i.mem[k], mref[k])
  endtask : op

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    for (int i = 0; i < 256; i++) mref[i] = 8'(i * 37) ^ 8'ha5;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK({busy, done, ok_o, ovf, ecode, mem.req}, 21'h0)
    op(1'b1, 16'h0000, 3'h0, 8'sd3, 1'b0, 1'b0, `BSR_ERR_NONE);
    op(1'b0, 16'h0000, 3'h0, -8'sd3, 1'b0, 1'b0, `BSR_ERR_NONE);
    op(1'b1, 16'h0021, 3'h4, 8'sd14, 1'b0, 1'b0, `BSR_ERR_NONE);
    slow = 1'b1;
    op(1'b1, 16'h0010, 3'h5, 8'sd64, 1'b0, 1'b0, `BSR_ERR_NONE);
    op(1'b0, 16'h0010, 3'h5, -8'sd64, 1'b0, 1'b0, `BSR_ERR_NONE);
    slow = 1'b0;
    op(1'b1, 16'h00ff, 3'h7, 8'sd1, 1'b0, 1'b0, `BSR_ERR_NONE);
    op(1'b1, 16'h00ff, 3'h7, 8'sd2, 1'b0, 1'b0, `BSR_ERR_RANGE);
    op(1'b1, 16'h0004, 3'h1, 8'sd0, 1'b0, 1'b0, `BSR_ERR_COUNT);
    op(1'b1, 16'h0004, 3'h1, 8'sd65, 1'b0, 1'b0, `BSR_ERR_COUNT);
    op(1'b1, 16'h0004, 3'h1, -8'sd65, 1'b0, 1'b0, `BSR_ERR_COUNT);
    op(1'b0, 16'h0004, 3'h1, 8'sd5, 1'b1, 1'b0, `BSR_ERR_NONE);
    op(1'b0, 16'h0004, 3'h1, 8'sd0, 1'b0, 1'b1, `BSR_ERR_INDIRECT);
    op(1'b0, 16'h0004, 3'h1, -8'sd9, 1'b0, 1'b0, `BSR_ERR_NONE);
    end_of_test();
  end
endmodule : tb_top
